//--- verilog/lsir_top.sv
// module: link status register, local interrupt status and priority vector logic
//
// Overview of operation
// RULE_01: status bits 27:24 show detected receive lane count, read only.
// RULE_02: status bits 23:20 show detected transmit lane count, read only.
// RULE_03: retiming option present bit 11 always reads zero.
// RULE_04: received flow-control enable sets bit 10 and stalls transmit until disable.
// RULE_05: sent flow-control enable sets bit 9, cleared by sent disable.
// RULE_06: received error control character sets bit 8; writing one clears it.
// RULE_07: inbound packet error sets bit 7; writing one clears it.
// RULE_08: error bit setting raises a module status interrupt only when enabled.
// RULE_09: bits 6 and 5 show slave outbound and read-return fifos not empty.
// RULE_10: bits 4 and 3 show master inbound and read-return fifos not empty.
// RULE_11: bits 2 and 1 show pending master and slave bus requests.
// RULE_12: bit 0 shows serial link initialisation has completed.
// RULE_13: reserved bits read zero and ignore writes.
// RULE_14: priority vector read returns lowest-numbered pending status bit in 4:0.
// RULE_15: priority vector bit 31 reads zero when anything pending, else one.
// RULE_16: priority vector write clears the status bit numbered by wdata 4:0.
// RULE_17: interrupt status register is write-one-to-clear; zeros leave bits alone.
// RULE_18: in local mode level interrupt is high while any status bit is set.
// RULE_19: enabled module status interrupt posts at the control vector bit position.
// RULE_20: local bit posts interrupts locally when set, forwards to peer when clear.
// RULE_21: in local mode pending/set bits merge into status, then pending clears.
// RULE_22: with nothing pending vector field 4:0 reads zero; writing it changes nothing.
`timescale 1ns/1ps
`default_nettype none

module lsir_top
  import lsir_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // register port
  input wire lsir_bus_s bus_i,
  output logic [31:0] rdata_o,
  // link side status levels and event pulses
  input wire lsir_link_s link_i,
  input wire lsir_evt_s evt_i,
  // peer forwarding of pending interrupts
  input wire logic fwd_ack_i,
  output logic [31:0] fwd_bits_o,
  output logic fwd_req_o,
  // flow control and interrupt
  output logic tx_stall_o,
  output logic level_irq_out_o
);

  // ==========================================================
  // state
  lsir_state_s st_r;
  lsir_state_s st_nxt;
  logic wr_ctrl;
  logic wr_status;
  logic wr_pvec;
  logic wr_isr;
  logic wr_pend;
  logic rem_set;
  logic loc_set;
  logic sts_evt;
  logic [31:0] isr_clr;
  logic [31:0] isr_set;
  logic [31:0] pend_set;
  logic [31:0] status_word;
  logic [31:0] pvec_word;

  always_comb begin
    st_nxt = st_r;
    wr_ctrl = bus_i.wr && (bus_i.addr == LSIR_CTRL_OFS);
    wr_status = bus_i.wr && (bus_i.addr == LSIR_STATUS_OFS);
    wr_pvec = bus_i.wr && (bus_i.addr == LSIR_PVEC_OFS);
    wr_isr = bus_i.wr && (bus_i.addr == LSIR_ISR_OFS);
    wr_pend = bus_i.wr && (bus_i.addr == LSIR_PEND_OFS);

    // control
    if (wr_ctrl) begin
      st_nxt.ctrl.intr_local = bus_i.wdata[LSIR_CTRL_LOCAL_BIT];
      st_nxt.ctrl.intr_en = bus_i.wdata[LSIR_CTRL_EN_BIT];
      st_nxt.ctrl.intr_vec = bus_i.wdata[LSIR_CTRL_VEC_LSB +: 5];
    end

    // flow control: set wins when both symbols land together
    if (evt_i.fc_on_rx) begin
      st_nxt.in_fc = 1'b1; // RULE_04
    end else if (evt_i.fc_off_rx) begin
      st_nxt.in_fc = 1'b0; // RULE_04
    end
    if (evt_i.fc_on_tx) begin
      st_nxt.out_fc = 1'b1; // RULE_05
    end else if (evt_i.fc_off_tx) begin
      st_nxt.out_fc = 1'b0; // RULE_05
    end

    // error flags: hardware set beats software clear
    rem_set = evt_i.err_char_rx && !st_r.rem_err;
    loc_set = evt_i.pkt_err && !st_r.loc_err;
    if (wr_status && bus_i.wdata[LSIR_ST_REMERR_BIT]) begin
      st_nxt.rem_err = 1'b0; // RULE_06
    end
    if (wr_status && bus_i.wdata[LSIR_ST_LOCERR_BIT]) begin
      st_nxt.loc_err = 1'b0; // RULE_07
    end
    if (evt_i.err_char_rx) begin
      st_nxt.rem_err = 1'b1; // RULE_06
    end
    if (evt_i.pkt_err) begin
      st_nxt.loc_err = 1'b1; // RULE_07
    end

    // a status interrupt fires on the flag's rising edge, not per event
    sts_evt = (rem_set || loc_set) && st_r.ctrl.intr_en; // RULE_08
    pend_set = '0;
    if (sts_evt) begin
      pend_set[st_r.ctrl.intr_vec] = 1'b1; // RULE_19
    end
    if (wr_pend) begin
      pend_set = pend_set | bus_i.wdata;
    end

    // pending/set: merged locally or held for the peer
    if (st_r.ctrl.intr_local) begin
      isr_set = st_r.pend; // RULE_21
      st_nxt.pend = pend_set; // RULE_20
    end else begin
      isr_set = '0;
      st_nxt.pend = (st_r.pend & ~({32{fwd_ack_i}})) | pend_set; // RULE_20
    end

    // status/clear: write-one-to-clear plus clear by vector number
    isr_clr = '0;
    if (wr_isr) begin
      isr_clr = bus_i.wdata; // RULE_17
    end
    if (wr_pvec) begin
      isr_clr[bus_i.wdata[4:0]] = 1'b1; // RULE_16 RULE_22
    end
    st_nxt.isr = (st_r.isr & ~isr_clr) | isr_set; // RULE_17
    st_nxt.irq = st_nxt.ctrl.intr_local && (st_nxt.isr != '0); // RULE_18

    // read words
    status_word = LSIR_WORD_RST; // RULE_13
    status_word[LSIR_ST_RXW_LSB +: 4] = link_i.rx_lanes; // RULE_01
    status_word[LSIR_ST_TXW_LSB +: 4] = link_i.tx_lanes; // RULE_02
    status_word[LSIR_ST_RTM_BIT] = 1'b0; // RULE_03
    status_word[LSIR_ST_INFC_BIT] = st_r.in_fc; // RULE_04
    status_word[LSIR_ST_OUTFC_BIT] = st_r.out_fc; // RULE_05
    status_word[LSIR_ST_REMERR_BIT] = st_r.rem_err;
    status_word[LSIR_ST_LOCERR_BIT] = st_r.loc_err;
    status_word[LSIR_ST_FIFO_LSB +: 4] = link_i.fifo_ne; // RULE_09 RULE_10
    status_word[LSIR_ST_MREQ_BIT] = link_i.mst_req; // RULE_11
    status_word[LSIR_ST_SREQ_BIT] = link_i.slv_req; // RULE_11
    status_word[LSIR_ST_LINK_BIT] = link_i.link_up; // RULE_12

    pvec_word = LSIR_WORD_RST; // RULE_13
    pvec_word[4:0] = lsir_first(st_r.isr); // RULE_14 RULE_22
    pvec_word[LSIR_PV_NONE_BIT] = (st_r.isr == '0); // RULE_15

    // read data stand only in the cycle after the strobe
    st_nxt.rdata = LSIR_WORD_RST;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        LSIR_CTRL_OFS: begin
          st_nxt.rdata[LSIR_CTRL_LOCAL_BIT] = st_r.ctrl.intr_local;
          st_nxt.rdata[LSIR_CTRL_EN_BIT] = st_r.ctrl.intr_en;
          st_nxt.rdata[LSIR_CTRL_VEC_LSB +: 5] = st_r.ctrl.intr_vec;
        end
        LSIR_STATUS_OFS: begin
          st_nxt.rdata = status_word;
        end
        LSIR_PVEC_OFS: begin
          st_nxt.rdata = pvec_word;
        end
        LSIR_ISR_OFS: begin
          st_nxt.rdata = st_r.isr;
        end
        LSIR_PEND_OFS: begin
          st_nxt.rdata = st_r.pend;
        end
        default: begin
          st_nxt.rdata = LSIR_WORD_RST;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign rdata_o = st_r.rdata;
  assign tx_stall_o = st_r.in_fc; // RULE_04
  assign level_irq_out_o = st_r.irq; // RULE_18
  assign fwd_bits_o = st_r.ctrl.intr_local ? '0 : st_r.pend;
  assign fwd_req_o = !st_r.ctrl.intr_local && (st_r.pend != '0); // RULE_20

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  lane_width_rd_a: assert property ( // RULE_01
    bus_i.rd && bus_i.addr == LSIR_STATUS_OFS |=>
      rdata_o[27:20] == $past({link_i.rx_lanes, link_i.tx_lanes}))
    else $error("lane widths misreported");

  status_rsvd_a: assert property ( // RULE_13
    bus_i.rd && bus_i.addr == LSIR_STATUS_OFS |=>
      rdata_o[31:28] == 4'h0 && rdata_o[19:11] == 9'h000)
    else $error("status reserved or retiming bit nonzero");

  stall_set_a: assert property ( // RULE_04
    evt_i.fc_on_rx |=> tx_stall_o)
    else $error("transmit stall not raised by enable symbol");

  stall_hold_a: assert property ( // RULE_04
    tx_stall_o && !evt_i.fc_off_rx |=> tx_stall_o)
    else $error("transmit stall dropped without disable symbol");

  stall_clr_a: assert property ( // RULE_04
    evt_i.fc_off_rx && !evt_i.fc_on_rx |=> !tx_stall_o)
    else $error("transmit stall kept after disable symbol");

  rem_err_set_a: assert property ( // RULE_06
    evt_i.err_char_rx |=> st_r.rem_err)
    else $error("remote error not latched");

  err_clr_a: assert property ( // RULE_07
    wr_status && bus_i.wdata[7] && !evt_i.pkt_err |=> !st_r.loc_err)
    else $error("local error not cleared by write one");

  vec_post_a: assert property ( // RULE_19
    evt_i.err_char_rx && !st_r.rem_err && st_r.ctrl.intr_en |=>
      st_r.pend[$past(st_r.ctrl.intr_vec)] ##1 (st_r.isr != '0 || !$past(st_r.ctrl.intr_local)))
    else $error("status interrupt not posted at vector");

  merge_pend_a: assert property ( // RULE_21
    st_r.ctrl.intr_local && st_r.pend != '0 |=>
      (st_r.isr & $past(st_r.pend)) == $past(st_r.pend))
    else $error("pending bits not merged into status");

  w1c_isr_a: assert property ( // RULE_17
    wr_isr && isr_set == '0 |=>
      (st_r.isr & $past(bus_i.wdata)) == '0 && (st_r.isr & ~$past(bus_i.wdata)) ==
      ($past(st_r.isr) & ~$past(bus_i.wdata)))
    else $error("write one to clear misbehaves");

  pvec_rd_a: assert property ( // RULE_14
    bus_i.rd && bus_i.addr == LSIR_PVEC_OFS |=>
      rdata_o[31] == ($past(st_r.isr) == '0) && rdata_o[30:5] == '0 &&
      rdata_o[4:0] == lsir_first($past(st_r.isr)))
    else $error("priority vector read wrong");

  level_irq_a: assert property ( // RULE_18
    (st_r.ctrl.intr_local && st_r.isr != '0 |-> level_irq_out_o) and
      (!st_r.ctrl.intr_local || st_r.isr == '0 |-> !level_irq_out_o))
    else $error("level interrupt not following status");

  pvec_clr_a: assert property ( // RULE_16
    wr_pvec && isr_set == '0 |=> !st_r.isr[$past(bus_i.wdata[4:0])])
    else $error("vector write did not clear bit");

  pvec_keep_a: assert property ( // RULE_16
    wr_pvec && isr_set == '0 |=>
      (st_r.isr & ~(32'h0000_0001 << $past(bus_i.wdata[4:0]))) ==
      ($past(st_r.isr) & ~(32'h0000_0001 << $past(bus_i.wdata[4:0]))))
    else $error("vector write touched other bits");

  pvec_none_a: assert property ( // RULE_22
    bus_i.rd && bus_i.addr == LSIR_PVEC_OFS && st_r.isr == '0 |=>
      rdata_o == 32'h8000_0000)
    else $error("empty priority vector read wrong");

  isr_keep_a: assert property ( // RULE_17
    !wr_isr && !wr_pvec |=> (st_r.isr & $past(st_r.isr)) == $past(st_r.isr))
    else $error("status bit lost without a clear");

  // ==========================================================
  // flow control and error flags
  out_fc_set_a: assert property ( // RULE_05
    evt_i.fc_on_tx |=> st_r.out_fc)
    else $error("outbound flow control not set");

  out_fc_clr_a: assert property ( // RULE_05
    evt_i.fc_off_tx && !evt_i.fc_on_tx |=> !st_r.out_fc)
    else $error("outbound flow control not cleared");

  fc_rd_a: assert property ( // RULE_04 RULE_05
    bus_i.rd && bus_i.addr == LSIR_STATUS_OFS |=>
      rdata_o[LSIR_ST_INFC_BIT] == $past(st_r.in_fc) &&
      rdata_o[LSIR_ST_OUTFC_BIT] == $past(st_r.out_fc))
    else $error("flow control bits misreported");

  rem_clr_a: assert property ( // RULE_06
    wr_status && bus_i.wdata[LSIR_ST_REMERR_BIT] && !evt_i.err_char_rx |=> !st_r.rem_err)
    else $error("remote error not cleared by write one");

  err_hold_a: assert property ( // RULE_06
    st_r.rem_err && !(wr_status && bus_i.wdata[LSIR_ST_REMERR_BIT]) |=> st_r.rem_err)
    else $error("remote error dropped without a clear");

  loc_set_a: assert property ( // RULE_07
    evt_i.pkt_err |=> st_r.loc_err)
    else $error("local error not latched");

  no_post_a: assert property ( // RULE_08
    !st_r.ctrl.intr_local && !st_r.ctrl.intr_en && !wr_pend |=>
      (st_r.pend & ~$past(st_r.pend)) == '0)
    else $error("status interrupt posted while disabled");

  // ==========================================================
  // status and control read words
  rtm_zero_a: assert property ( // RULE_03
    bus_i.rd && bus_i.addr == LSIR_STATUS_OFS |=> !rdata_o[LSIR_ST_RTM_BIT])
    else $error("retiming option bit set");

  fifo_rd_a: assert property ( // RULE_09 RULE_10
    bus_i.rd && bus_i.addr == LSIR_STATUS_OFS |=>
      rdata_o[LSIR_ST_FIFO_LSB +: 4] == $past(link_i.fifo_ne))
    else $error("fifo flags misreported");

  req_link_rd_a: assert property ( // RULE_11 RULE_12
    bus_i.rd && bus_i.addr == LSIR_STATUS_OFS |=>
      rdata_o[2:0] == $past({link_i.mst_req, link_i.slv_req, link_i.link_up}))
    else $error("request or link bits misreported");

  ctrl_rd_a: assert property ( // RULE_19 RULE_13
    bus_i.rd && bus_i.addr == LSIR_CTRL_OFS |=>
      rdata_o[LSIR_CTRL_VEC_LSB +: 5] == $past(st_r.ctrl.intr_vec) &&
      rdata_o[31:15] == '0 && rdata_o[7:0] == '0)
    else $error("control read wrong");

  rd_idle_a: assert property ( // RULE_13
    !bus_i.rd |=> rdata_o == '0)
    else $error("read data outside read cycle");

  // ==========================================================
  // pending bits, forwarding and merge
  fwd_hold_a: assert property ( // RULE_20
    !st_r.ctrl.intr_local && !fwd_ack_i |=>
      (st_r.pend & $past(st_r.pend)) == $past(st_r.pend))
    else $error("pending bits lost before forwarding");

  fwd_clr_a: assert property ( // RULE_20
    !st_r.ctrl.intr_local && fwd_ack_i && !wr_pend && !sts_evt |=> st_r.pend == '0)
    else $error("forwarded bits not cleared");

  remote_isr_a: assert property ( // RULE_20
    !st_r.ctrl.intr_local |=> (st_r.isr & ~$past(st_r.isr)) == '0)
    else $error("remote mode posted locally");

  local_pend_a: assert property ( // RULE_21
    st_r.ctrl.intr_local && !wr_pend && !sts_evt |=> st_r.pend == '0)
    else $error("pending bits not cleared after merge");

  err_to_irq_c: cover property (
    st_r.ctrl.intr_local && st_r.ctrl.intr_en && evt_i.pkt_err ##[1:4] level_irq_out_o);
  stall_cycle_c: cover property (evt_i.fc_on_rx ##[1:8] evt_i.fc_off_rx ##1 !tx_stall_o);
  pvec_read_c: cover property (bus_i.rd && bus_i.addr == LSIR_PVEC_OFS && st_r.isr != '0);
  fwd_ack_c: cover property (fwd_req_o && fwd_ack_i);
  err_both_c: cover property (wr_status && bus_i.wdata[LSIR_ST_REMERR_BIT] && evt_i.err_char_rx);

endmodule

`default_nettype wire

//--- verilog/lsir_pkg.sv
// package: register map, field layout and carriers for the link status and interrupt block
package lsir_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] LSIR_CTRL_OFS = 8'h04;
  localparam logic [7:0] LSIR_STATUS_OFS = 8'h08;
  localparam logic [7:0] LSIR_PVEC_OFS = 8'h0C;
  localparam logic [7:0] LSIR_ISR_OFS = 8'h10;
  localparam logic [7:0] LSIR_PEND_OFS = 8'h14;

  // ==========================================================
  // field positions
  localparam int LSIR_CTRL_LOCAL_BIT = 14;
  localparam int LSIR_CTRL_EN_BIT = 13;
  localparam int LSIR_CTRL_VEC_LSB = 8;
  localparam int LSIR_ST_RXW_LSB = 24;
  localparam int LSIR_ST_TXW_LSB = 20;
  localparam int LSIR_ST_RTM_BIT = 11;
  localparam int LSIR_ST_INFC_BIT = 10;
  localparam int LSIR_ST_OUTFC_BIT = 9;
  localparam int LSIR_ST_REMERR_BIT = 8;
  localparam int LSIR_ST_LOCERR_BIT = 7;
  localparam int LSIR_ST_FIFO_LSB = 3;
  localparam int LSIR_ST_MREQ_BIT = 2;
  localparam int LSIR_ST_SREQ_BIT = 1;
  localparam int LSIR_ST_LINK_BIT = 0;
  localparam int LSIR_PV_NONE_BIT = 31;

  // ==========================================================
  // reset values
  localparam logic [31:0] LSIR_WORD_RST = 32'h0000_0000;
  localparam logic [4:0] LSIR_VEC_RST = 5'h00;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lsir_bus_s;

  typedef struct packed {
    logic [3:0] rx_lanes;
    logic [3:0] tx_lanes;
    logic [3:0] fifo_ne;
    logic mst_req;
    logic slv_req;
    logic link_up;
  } lsir_link_s;

  typedef struct packed {
    logic fc_on_rx;
    logic fc_off_rx;
    logic fc_on_tx;
    logic fc_off_tx;
    logic err_char_rx;
    logic pkt_err;
  } lsir_evt_s;

  typedef struct packed {
    logic intr_local;
    logic intr_en;
    logic [4:0] intr_vec;
  } lsir_ctrl_s;

  typedef struct packed {
    lsir_ctrl_s ctrl;
    logic in_fc;
    logic out_fc;
    logic rem_err;
    logic loc_err;
    logic [31:0] pend;
    logic [31:0] isr;
    logic [31:0] rdata;
    logic irq;
  } lsir_state_s;

  // lowest set bit wins: bit 0 is the most urgent vector
  function automatic logic [4:0] lsir_first(input logic [31:0] v);
    logic [4:0] idx;
    idx = LSIR_VEC_RST;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

endpackage

//--- verification/lsir_host.sv
// host model: register port master issuing one-cycle read and write strobes
`timescale 1ns/1ps
`default_nettype none
module lsir_host
  import lsir_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // register port
  output var lsir_bus_s bus_o,
  input wire logic [31:0] rdata_i
);
  initial bus_o = '0;
  // ==========================================================
  // bus cycles
  // released address and data are inverted so stale values are never trusted
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge ref_clk_i);
    bus_o <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    bus_o <= '{addr: ~a, wdata: ~w, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    bus_o <= '{addr: a, wdata: ~bus_o.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    bus_o <= '{addr: ~a, wdata: ~bus_o.wdata, wr: 1'b0, rd: 1'b0};
    #1;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// testbench: self-checking bench for the link status and interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
  import lsir_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  lsir_bus_s bus;
  lsir_link_s link = '0;
  lsir_evt_s evt = '0;
  logic fwd_ack = 1'b0;
  logic [31:0] rdata, fwd_bits, isr_m, m;
  logic fwd_req, stall, irq;
  logic in_fc_m = 1'b0, out_fc_m = 1'b0, rem_m = 1'b0, loc_m = 1'b0;
  int seed = 9788;
  int n_fail = 0;
  int n_compared = 0;
  int v;
  always #10 ref_clk_i = ~ref_clk_i;
  lsir_host i_host (.ref_clk_i(ref_clk_i), .bus_o(bus), .rdata_i(rdata));
  lsir_top i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
    .link_i(link), .evt_i(evt), .fwd_ack_i(fwd_ack), .fwd_bits_o(fwd_bits),
    .fwd_req_o(fwd_req), .tx_stall_o(stall), .level_irq_out_o(irq));
  // ==========================================================
  // reference model
  function automatic logic [31:0] status_exp();
    return {4'h0, link.rx_lanes, link.tx_lanes, 8'h00, 1'b0, in_fc_m, out_fc_m, rem_m,
      loc_m, link.fifo_ne, link.mst_req, link.slv_req, link.link_up};
  endfunction
  function automatic logic [31:0] pvec_exp(input logic [31:0] s);
    logic [31:0] r;
    r = 32'h8000_0000;
    for (int i = 31; i >= 0; i--) begin
      if (s[i]) begin
        r = 32'(i);
      end
    end
    return r;
  endfunction
  // ==========================================================
  // helpers
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    i_host.rd(a, d);
    `CHK(nm, e, d)
  endtask
  task automatic pulse(input logic [5:0] e);
    @(posedge ref_clk_i);
    evt <= lsir_evt_s'(e);
    @(posedge ref_clk_i);
    evt <= '0;
  endtask
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    stop_test();
  end
  // ==========================================================
  // scenarios
  initial begin
    isr_m = '0;
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk_i);
      link <= lsir_link_s'(15'($random(seed)));
      i_host.wr(LSIR_STATUS_OFS, 32'hFFFF_FE7F);
      chk_rd(LSIR_STATUS_OFS, status_exp(), "status");
      chk_rd(LSIR_STATUS_OFS, status_exp(), "status");
    end
    pulse(6'b101000);
    in_fc_m = 1'b1;
    out_fc_m = 1'b1;
    chk_rd(LSIR_STATUS_OFS, status_exp(), "fc set");
    `CHK("stall", 1'b1, stall)
    pulse(6'b010100);
    in_fc_m = 1'b0;
    out_fc_m = 1'b0;
    chk_rd(LSIR_STATUS_OFS, status_exp(), "fc clear");
    `CHK("stall", 1'b0, stall)
    v = {$random(seed)} % 32;
    i_host.wr(LSIR_CTRL_OFS, 32'h0000_6000 | (v << 8));
    pulse(6'b000010);
    rem_m = 1'b1;
    isr_m[v] = 1'b1;
    chk_rd(LSIR_STATUS_OFS, status_exp(), "rem err");
    chk_rd(LSIR_ISR_OFS, isr_m, "posted");
    `CHK("irq", 1'b1, irq)
    chk_rd(LSIR_PVEC_OFS, 32'(v), "pvec");
    i_host.wr(LSIR_STATUS_OFS, 32'h0000_0100);
    rem_m = 1'b0;
    pulse(6'b000001);
    loc_m = 1'b1;
    chk_rd(LSIR_STATUS_OFS, status_exp(), "loc err");
    i_host.wr(LSIR_STATUS_OFS, 32'h0000_0080);
    loc_m = 1'b0;
    chk_rd(LSIR_STATUS_OFS, status_exp(), "err w1c");
    i_host.wr(LSIR_PVEC_OFS, 32'hFFFF_FFE0 | 32'(v));
    isr_m[v] = 1'b0;
    chk_rd(LSIR_PVEC_OFS, 32'h8000_0000, "pvec none");
    `CHK("irq", 1'b0, irq)
    i_host.wr(LSIR_CTRL_OFS, 32'h0000_4000);
    for (int k = 0; k < 6; k++) begin
      m = $random(seed);
      i_host.wr(LSIR_PEND_OFS, m);
      isr_m = isr_m | m;
      chk_rd(LSIR_ISR_OFS, isr_m, "isr");
      chk_rd(LSIR_PVEC_OFS, pvec_exp(isr_m), "pvec");
      `CHK("fwd bits local", 32'h0000_0000, fwd_bits)
      m = $random(seed);
      i_host.wr(LSIR_ISR_OFS, m);
      isr_m = isr_m & ~m;
      chk_rd(LSIR_ISR_OFS, isr_m, "isr w1c");
    end
    i_host.wr(LSIR_ISR_OFS, 32'hFFFF_FFFF);
    isr_m = '0;
    pulse(6'b000011);
    rem_m = 1'b1;
    loc_m = 1'b1;
    chk_rd(LSIR_ISR_OFS, isr_m, "no post");
    `CHK("irq", 1'b0, irq)
    chk_rd(LSIR_STATUS_OFS, status_exp(), "both err");
    i_host.wr(LSIR_STATUS_OFS, 32'h0000_0180);
    rem_m = 1'b0;
    loc_m = 1'b0;
    chk_rd(LSIR_STATUS_OFS, status_exp(), "both w1c");
    i_host.wr(LSIR_CTRL_OFS, 32'h0000_0000);
    m = $random(seed) | 32'h0000_0001;
    i_host.wr(LSIR_PEND_OFS, m);
    repeat (2) @(posedge ref_clk_i);
    #1;
    `CHK("fwd req", 1'b1, fwd_req)
    `CHK("fwd bits", m, fwd_bits)
    chk_rd(LSIR_ISR_OFS, 32'h0000_0000, "isr remote");
    @(posedge ref_clk_i);
    fwd_ack <= 1'b1;
    @(posedge ref_clk_i);
    fwd_ack <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    `CHK("fwd req", 1'b0, fwd_req)
    chk_rd(8'h20, 32'h0000_0000, "unmapped");
    i_host.wr(LSIR_PEND_OFS, m);
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    `CHK("fwd req rst", 1'b0, fwd_req)
    `CHK("fwd bits rst", 32'h0000_0000, fwd_bits)
    @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    chk_rd(LSIR_PEND_OFS, 32'h0000_0000, "pend rst");
    chk_rd(LSIR_PVEC_OFS, 32'h8000_0000, "pvec rst");
    stop_test();
  end
endmodule
`default_nettype wire
